/* File: design/fepc_regs.sv */
// EEPROM protection, command object windows and option byte behind AXI4-Lite.
// Assumes the nonvolatile bytes are stable at reset release and that op requests
// come from the command sequencer in the sys_clk domain.
//
// Summary of operation
// R1: A write to the protection size field takes effect only if the new value exceeds the current one.
// R2: The protection open bit may be written only from 1 to 0, a write back to 1 is ignored.
// R3: Bit 7 of the protection register at 0 blocks program and erase over the sized range, at 1 disables protection.
// R4: With the open bit set the size field plays no part in the protection decision.
// R5: The open bit and size field are loaded at reset from the nonvolatile byte at 0x040C.
// R6: A program or erase hitting a protected EEPROM area is refused and sets the violation flag in the status register.
// R7: An EEPROM block erase is refused while any EEPROM sector is protected.
// R8: Bits 6 to 3 of the protection register are read-only and read as zero.
// R9: The command object holds six 16-bit words, the windows show the word chosen by the index.
// R10: The command object is read and written a byte at a time, high window bits 15:8, low window bits 7:0.
// R11: All eight option bits are loaded at reset from the nonvolatile byte at 0x040F and read back by software.
// R12: The size field sits in bits 2 to 0 and a larger value protects a larger EEPROM region.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
module fepc_regs
	import fepc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// AXI4-Lite write address and data
	input wire logic [FEPC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [FEPC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Nonvolatile configuration bytes
	input wire logic [7:0] nv_eeprom_protection_byte,
	input wire logic [7:0] nv_option_byte,
	// EEPROM operation check
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic [FEPC_EE_ADDR_W-1:0] op_addr,
	output logic op_accept,
	output logic op_refuse,
	// Configuration and interrupt
	output logic [7:0] option_bits,
	output logic irq
);
	// ****************************************
	// State
	// ****************************************
	logic load_pend_q;
	logic [7:0] eeprom_protection_q;
	logic [7:0] option_q;
	logic [FEPC_COB_IDX_W-1:0] cob_index_q;
	logic [15:0] cob_word_q [FEPC_COB_WORDS];
	logic viol_q;
	logic [FEPC_IRQ_W-1:0] irq_stat_q;
	logic [FEPC_IRQ_W-1:0] irq_mask_q;
	logic op_accept_q;
	logic op_refuse_q;
	logic aw_have_q;
	logic [5:0] aw_idx_q;
	logic w_have_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ****************************************
	// Bus handshakes
	// ****************************************
	// Held off during the nonvolatile load so no write races the load
	assign s_axi_awready = !aw_have_q && !bvalid_q && !load_pend_q;
	assign s_axi_wready = !w_have_q && !bvalid_q && !load_pend_q;
	assign s_axi_arready = !rvalid_q && !load_pend_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign op_accept = op_accept_q;
	assign op_refuse = op_refuse_q;
	assign option_bits = option_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_do;
	logic [5:0] ar_idx;
	logic cob_sel_ok;
	logic [15:0] cob_sel;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign wr_do = aw_have_q && w_have_q;
	assign ar_idx = s_axi_araddr[7:2];
	assign cob_sel_ok = cob_index_q < FEPC_COB_IDX_W'(FEPC_COB_WORDS); // R9
	assign cob_sel = cob_sel_ok ? cob_word_q[cob_index_q] : 16'h0000; // R9

	logic wr_lo;
	logic [7:0] wr_byte;
	assign wr_lo = wr_do && wstrb_q[0];
	assign wr_byte = wdata_q[7:0];

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_have_q <= 1'b0;
			aw_idx_q <= 6'h00;
			w_have_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_have_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr[7:2];
			end
			else if (wr_do)
				aw_have_q <= 1'b0;
			if (w_take)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (wr_do)
				w_have_q <= 1'b0;
		end
	end

	// ****************************************
	// Write response
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= FEPC_RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_q <= 1'b1;
			unique case (aw_idx_q)
				FEPC_IDX_CMD_INDEX, FEPC_IDX_STATUS, FEPC_IDX_EEPROM_PROTECTION, FEPC_IDX_COB_HI,
				FEPC_IDX_COB_LO, FEPC_IDX_OPTION, FEPC_IDX_IRQ_STATUS, FEPC_IDX_IRQ_MASK:
					bresp_q <= FEPC_RESP_OKAY;
				default:
					bresp_q <= FEPC_RESP_SLVERR;
			endcase
		end
		else if (bvalid_q && s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// ****************************************
	// Protection register and option byte
	// ****************************************
	logic [2:0] size_q;
	logic open_q;
	assign size_q = eeprom_protection_q[FEPC_SIZE_MSB:0];
	assign open_q = eeprom_protection_q[FEPC_OPEN_BIT];

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			load_pend_q <= 1'b1;
			eeprom_protection_q <= FEPC_EEPROM_PROTECTION_RST;
			option_q <= 8'h00;
		end
		else if (load_pend_q)
		begin
			// Straps caught on the first edge after release
			load_pend_q <= 1'b0;
			eeprom_protection_q <= nv_eeprom_protection_byte & FEPC_EEPROM_PROTECTION_LOAD_MASK; // R5 R8 R12
			option_q <= nv_option_byte; // R11
		end
		else if (wr_lo && aw_idx_q == FEPC_IDX_EEPROM_PROTECTION)
		begin
			if (wr_byte[FEPC_SIZE_MSB:0] > size_q)
				eeprom_protection_q[FEPC_SIZE_MSB:0] <= wr_byte[FEPC_SIZE_MSB:0]; // R1 R12
			if (!wr_byte[FEPC_OPEN_BIT])
				eeprom_protection_q[FEPC_OPEN_BIT] <= 1'b0; // R2
		end
	end

	// ****************************************
	// Command object index and array
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			cob_index_q <= '0;
		else if (wr_lo && aw_idx_q == FEPC_IDX_CMD_INDEX)
			cob_index_q <= wr_byte[FEPC_COB_IDX_W-1:0];
	end

	// Out-of-range index: writes dropped, windows read zero
	for (genvar i = 0; i < FEPC_COB_WORDS; i++)
	begin : g_cob
		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
				cob_word_q[i] <= 16'h0000;
			else if (wr_lo && cob_index_q == FEPC_COB_IDX_W'(i))
			begin
				if (aw_idx_q == FEPC_IDX_COB_HI)
					cob_word_q[i][15:8] <= wr_byte; // R9 R10
				else if (aw_idx_q == FEPC_IDX_COB_LO)
					cob_word_q[i][7:0] <= wr_byte; // R9 R10
			end
		end
	end

	// ****************************************
	// Protection check on EEPROM operations
	// ****************************************
	logic [2:0] op_sector;
	logic hit_prot;
	logic refuse_now;
	assign op_sector = op_addr[FEPC_EE_ADDR_W-1:FEPC_EE_SECT_LSB];
	// Sectors 0 up to the size value are guarded
	assign hit_prot = !open_q && (op_sector <= size_q); // R3 R4 R12
	always_comb
	begin
		refuse_now = 1'b0;
		unique case (fepc_op_t'(op_kind))
			FEPC_OP_PROGRAM, FEPC_OP_SECTOR_ERASE:
				refuse_now = hit_prot; // R6
			FEPC_OP_BLOCK_ERASE:
				refuse_now = !open_q; // R7
			FEPC_OP_READ:
				refuse_now = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			op_accept_q <= 1'b0;
			op_refuse_q <= 1'b0;
		end
		else
		begin
			op_accept_q <= op_valid && !refuse_now;
			op_refuse_q <= op_valid && refuse_now; // R6 R7
		end
	end

	// ****************************************
	// Status flag and interrupts
	// ****************************************
	logic irq_rd_clr;
	assign irq_rd_clr = ar_take && ar_idx == FEPC_IDX_IRQ_STATUS;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			viol_q <= 1'b0;
		else if (op_refuse_q)
			viol_q <= 1'b1; // R6
		else if (wr_lo && aw_idx_q == FEPC_IDX_STATUS && wr_byte[FEPC_VIOL_BIT])
			viol_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			irq_stat_q <= '0;
		else
		begin
			// New events win over a same-cycle read clear
			irq_stat_q[FEPC_IRQ_VIOL_BIT] <= op_refuse_q || (irq_stat_q[FEPC_IRQ_VIOL_BIT] && !irq_rd_clr);
			irq_stat_q[FEPC_IRQ_DONE_BIT] <= op_accept_q || (irq_stat_q[FEPC_IRQ_DONE_BIT] && !irq_rd_clr);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			irq_mask_q <= '0;
		else if (wr_lo && aw_idx_q == FEPC_IDX_IRQ_MASK)
			irq_mask_q <= wr_byte[FEPC_IRQ_W-1:0];
	end

	// ****************************************
	// Read channel
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= FEPC_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= FEPC_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			unique case (ar_idx)
				FEPC_IDX_CMD_INDEX:
					rdata_q[FEPC_COB_IDX_W-1:0] <= cob_index_q;
				FEPC_IDX_STATUS:
					rdata_q[FEPC_VIOL_BIT] <= viol_q;
				FEPC_IDX_EEPROM_PROTECTION:
					rdata_q[7:0] <= {open_q, 4'h0, size_q}; // R8
				FEPC_IDX_COB_HI:
					rdata_q[7:0] <= cob_sel[15:8]; // R10
				FEPC_IDX_COB_LO:
					rdata_q[7:0] <= cob_sel[7:0]; // R10
				FEPC_IDX_OPTION:
					rdata_q[7:0] <= option_q; // R11
				FEPC_IDX_IRQ_STATUS:
					rdata_q[FEPC_IRQ_W-1:0] <= irq_stat_q;
				FEPC_IDX_IRQ_MASK:
					rdata_q[FEPC_IRQ_W-1:0] <= irq_mask_q;
				default:
					rresp_q <= FEPC_RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end
endmodule : fepc_regs

/* File: design/fepc_pkg.sv */
// Constants for the EEPROM protection and command object register block.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
package fepc_pkg;
	// ****************************************
	// Register indexes, byte address = 4 * index
	// ****************************************
	localparam logic [5:0] FEPC_IDX_CMD_INDEX = 6'h01;
	localparam logic [5:0] FEPC_IDX_STATUS = 6'h05;
	localparam logic [5:0] FEPC_IDX_EEPROM_PROTECTION = 6'h09;
	localparam logic [5:0] FEPC_IDX_COB_HI = 6'h0A;
	localparam logic [5:0] FEPC_IDX_COB_LO = 6'h0B;
	localparam logic [5:0] FEPC_IDX_OPTION = 6'h0C;
	localparam logic [5:0] FEPC_IDX_IRQ_STATUS = 6'h10;
	localparam logic [5:0] FEPC_IDX_IRQ_MASK = 6'h11;
	localparam int FEPC_ADDR_W = 8;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int FEPC_OPEN_BIT = 7;
	localparam int FEPC_SIZE_MSB = 2;
	localparam int FEPC_VIOL_BIT = 5;
	localparam int FEPC_IRQ_VIOL_BIT = 0;
	localparam int FEPC_IRQ_DONE_BIT = 1;
	localparam int FEPC_IRQ_W = 2;
	// ****************************************
	// Command object array
	// ****************************************
	localparam int FEPC_COB_WORDS = 6;
	localparam int FEPC_COB_IDX_W = 3;
	// ****************************************
	// EEPROM geometry, sector number taken from the top address bits
	// ****************************************
	localparam int FEPC_EE_ADDR_W = 8;
	localparam int FEPC_EE_SECT_LSB = 5;
	// ****************************************
	// Nonvolatile source addresses and reset values
	// ****************************************
	localparam logic [15:0] FEPC_NV_EEPROM_PROTECTION_ADDR = 16'h040C;
	localparam logic [15:0] FEPC_NV_OPTION_ADDR = 16'h040F;
	localparam logic [7:0] FEPC_EEPROM_PROTECTION_RST = 8'h80;
	localparam logic [7:0] FEPC_EEPROM_PROTECTION_LOAD_MASK = 8'h87;
	// ****************************************
	// Operation kinds and bus responses
	// ****************************************
	typedef enum logic [1:0] {
		FEPC_OP_PROGRAM,
		FEPC_OP_SECTOR_ERASE,
		FEPC_OP_BLOCK_ERASE,
		FEPC_OP_READ
	} fepc_op_t;
	localparam logic [1:0] FEPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] FEPC_RESP_SLVERR = 2'h2;
endpackage : fepc_pkg

/* File: testbench/fepc_regs_checker.sv */
// Port-level assertions for the protection and command object block.
// Assumes one sys_clk domain and the active low nrst.
`timescale 1ns/100ps
module fepc_regs_checker
	import fepc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Bus handshakes
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Ops and option byte
	input wire logic [7:0] nv_option_byte,
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic op_accept,
	input wire logic op_refuse,
	input wire logic [7:0] option_bits
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_one_answer: assert property (op_valid |=> op_accept != op_refuse)
		else $error("op check gave no single answer");
	a_quiet_idle: assert property (!op_valid |=> !op_accept && !op_refuse)
		else $error("op answer without a request");
	a_read_allowed: assert property (op_valid && op_kind == 2'h3 |=> op_accept)
		else $error("read op was refused");
	a_option_load: assert property ($rose(nrst) |=> option_bits == $past(nv_option_byte))
		else $error("option byte not loaded at reset");
	// Two deep so the load edge itself is excluded
	a_option_keep: assert property ($past(nrst, 2) |-> $stable(option_bits))
		else $error("option byte changed after load");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
endmodule : fepc_regs_checker

bind fepc_regs fepc_regs_checker u_chk (.sys_clk, .nrst, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .nv_option_byte, .op_valid, .op_kind, .op_accept,
	.op_refuse, .option_bits);

/* File: testbench/tb_fepc_regs.sv */
// Self-checking bench for the protection and command object registers.
// Assumes the package constants and a 200 MHz sys_clk.
`timescale 1ns/100ps
module tb_fepc_regs
	import fepc_pkg::*;
;
	logic sys_clk = 1'b0, nrst = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, op_valid = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, op_accept, op_refuse, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, op_addr = 8'h00, option_bits;
	logic [7:0] nv_eeprom_protection_byte = 8'hF9, nv_option_byte = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [1:0] op_kind = 2'h0, s_axi_bresp, s_axi_rresp, rsp, wrsp;
	logic [15:0] seed = 16'h0011;
	logic [15:0] cob [6];
	int failures = 0, num_checks = 0;
	fepc_regs u_dut (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .nv_eeprom_protection_byte, .nv_option_byte, .op_valid, .op_kind, .op_addr, .op_accept,
		.op_refuse, .option_bits, .irq);
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ****
	// Helpers
	// ****
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Protected sectors run from 0 up to the size field
	function automatic logic refuse_exp(input logic [1:0] k, input logic [7:0] a, input logic [7:0] p);
		return !p[7] && k != 2'h3 && (k == 2'h2 || a[7:5] <= p[2:0]);
	endfunction : refuse_exp
	task automatic final_report();
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic aw, w;
		logic b = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !b; n++)
		begin
			@(negedge sys_clk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			wrsp = s_axi_bresp;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b)
		begin
			failures++;
			final_report();
		end
	endtask : wr
	task automatic rd_reg(input logic [5:0] i);
		logic ar;
		logic r = 1'b0;
		@(posedge sys_clk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !r; n++)
		begin
			@(negedge sys_clk);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		if (!r)
		begin
			failures++;
			final_report();
		end
	endtask : rd_reg
	task automatic op(input logic [1:0] k, input logic [7:0] a, input logic [7:0] p);
		logic e;
		e = refuse_exp(k, a, p);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_addr <= a;
		@(posedge sys_clk);
		op_valid <= 1'b0;
		#1;
		chk({30'h0, op_accept, op_refuse}, {30'h0, !e, e});
	endtask : op
	// ****
	// Main sequence
	// ****
	logic [7:0] wv [4] = '{8'h00, 8'h83, 8'h02, 8'h7C};
	logic [7:0] ev [4] = '{8'h01, 8'h03, 8'h03, 8'h04};
	initial
	begin
		seed = lfsr(seed);
		nv_option_byte = seed[7:0];
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(FEPC_IDX_OPTION);
		chk(rd, {24'h0, nv_option_byte});
		rd_reg(FEPC_IDX_EEPROM_PROTECTION);
		chk(rd, 32'h81);
		op(2'h0, 8'h00, 8'h81);
		op(2'h2, 8'hE0, 8'h81);
		for (int i = 0; i < 4; i++)
		begin
			wr(FEPC_IDX_EEPROM_PROTECTION, wv[i]);
			rd_reg(FEPC_IDX_EEPROM_PROTECTION);
			chk(rd, {24'h0, ev[i]});
		end
		op(2'h1, 8'h80, 8'h04);
		op(2'h0, 8'hA0, 8'h04);
		for (int i = 0; i < 40; i++)
		begin
			seed = lfsr(seed);
			op(seed[1:0], seed[15:8], 8'h04);
		end
		rd_reg(FEPC_IDX_STATUS);
		chk(rd[FEPC_VIOL_BIT], 1'b1);
		wr(FEPC_IDX_STATUS, 8'h20);
		rd_reg(FEPC_IDX_STATUS);
		chk(rd[FEPC_VIOL_BIT], 1'b0);
		rd_reg(FEPC_IDX_IRQ_STATUS);
		chk(rd, 32'h3);
		wr(FEPC_IDX_IRQ_MASK, 8'h01);
		op(2'h3, 8'h00, 8'h04);
		@(posedge sys_clk);
		#1;
		chk(irq, 1'b0);
		op(2'h0, 8'h00, 8'h04);
		@(posedge sys_clk);
		#1;
		chk(irq, 1'b1);
		rd_reg(FEPC_IDX_IRQ_STATUS);
		chk(rd, 32'h3);
		chk(irq, 1'b0);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			cob[i] = seed;
			wr(FEPC_IDX_CMD_INDEX, 8'(i));
			wr(FEPC_IDX_COB_HI, seed[15:8]);
			wr(FEPC_IDX_COB_LO, seed[7:0]);
		end
		for (int i = 0; i < 7; i++)
		begin
			wr(FEPC_IDX_CMD_INDEX, 8'(i));
			rd_reg(FEPC_IDX_COB_HI);
			chk(rd, (i < 6) ? {24'h0, cob[i][15:8]} : 32'h0);
			rd_reg(FEPC_IDX_COB_LO);
			chk(rd, (i < 6) ? {24'h0, cob[i][7:0]} : 32'h0);
		end
		wr(FEPC_IDX_OPTION, ~nv_option_byte);
		chk(wrsp, FEPC_RESP_OKAY);
		rd_reg(FEPC_IDX_OPTION);
		chk(rd, {24'h0, nv_option_byte});
		rd_reg(6'h3F);
		chk(rsp, FEPC_RESP_SLVERR);
		wr(6'h3E, 8'h00);
		chk(wrsp, FEPC_RESP_SLVERR);
		// ****
		// Mid-run reset reloads both nonvolatile bytes
		// ****
		@(posedge sys_clk);
		seed = lfsr(seed);
		nv_eeprom_protection_byte <= seed[15:8];
		nv_option_byte <= seed[7:0];
		nrst <= 1'b0;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_reg(FEPC_IDX_EEPROM_PROTECTION);
		chk(rd, {24'h0, nv_eeprom_protection_byte[7], 4'h0, nv_eeprom_protection_byte[2:0]});
		rd_reg(FEPC_IDX_OPTION);
		chk(rd, {24'h0, nv_option_byte});
		chk({24'h0, option_bits}, {24'h0, nv_option_byte});
		final_report();
	end
endmodule : tb_fepc_regs
